// ---- core/pin_strap_config.sv ----
// pin strap capture, line coding, rts/cts use, shared pins, host select
// assumes synchronous inputs on clk; uart core supplies data and flags
`timescale 1ns/1ps
module pin_strap_config (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_up,
  // straps
  input wire logic infrared_mode_strap_n,
  input wire logic half_duplex_dir_strap_n,
  input wire logic host_i2c_sel,
  // host select pins
  input wire logic addr_sel0_or_chip_select_n,
  input wire logic addr_sel1_or_serial_in,
  // uart core side
  input wire logic [1:0] core_tx_data,
  input wire logic [1:0] core_tx_active,
  input wire logic core_irq,
  input wire logic auto_rts_en,
  input wire logic auto_cts_en,
  input wire logic rx_room,
  input wire logic sw_rts,
  input wire logic [7:0] io_function_control,
  input wire logic [7:0] io_direction_control,
  input wire logic [7:0] gpio_out_val,
  input wire logic [3:0] modem_out_val,
  // serial pins
  input wire logic [1:0] rx_pin,
  output logic [1:0] tx_pin,
  output logic chan_a_request_to_send_n,
  input wire logic chan_a_clear_to_send_n,
  // interrupt pin, open drain
  output logic irq_out,
  output logic irq_oe,
  // shared pins: term ready a, term ready b, set ready a, carrier a
  input wire logic [3:0] shared_pin_in,
  output logic [3:0] shared_pin_out,
  output logic [3:0] shared_pin_oe,
  // status to core
  output logic ir_mode,
  output logic half_duplex_mode,
  output logic i2c_mode,
  output logic [6:0] i2c_slave_addr,
  output logic spi_select,
  output logic tx_allowed,
  output logic cts_level,
  output logic [1:0] rx_to_core,
  output logic [3:0] shared_level
);
  ////////////////////////////////////////////////////////////////////
  // strap capture
  logic ir_r, ir_nxt, hd_r, hd_nxt, i2c_r, i2c_nxt;

  always_comb begin
    ir_nxt = ir_r;
    hd_nxt = hd_r;
    i2c_nxt = i2c_r;
    if (power_up) begin
      ir_nxt = !infrared_mode_strap_n;
      hd_nxt = !half_duplex_dir_strap_n;
      i2c_nxt = host_i2c_sel;
    end // otherwise held
  end

  // straps survive pin reset; only power_up reloads them
  always_ff @(posedge clk) begin
    ir_r <= ir_nxt;
    hd_r <= hd_nxt;
    i2c_r <= i2c_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // line and control outputs
  logic [1:0] tx_r, tx_nxt, rx_r, rx_nxt;
  logic rts_r, rts_nxt, irq_oe_r, irq_oe_nxt, gate_r, gate_nxt;
  logic cts_r, cts_nxt, cs_r, cs_nxt;
  logic [6:0] addr_r, addr_nxt;
  strap_pkg::rts_use_e rts_use;

  always_comb begin
    if (hd_r)
      rts_use = strap_pkg::rts_half_duplex;
    else if (auto_rts_en)
      rts_use = strap_pkg::rts_auto_flow;
    else
      rts_use = strap_pkg::rts_general;
    for (int i = 0; i < 2; i++) begin
      if (!core_tx_active[i])
        tx_nxt[i] = !ir_r;
      else
        tx_nxt[i] = core_tx_data[i];
      rx_nxt[i] = !ir_r && rx_pin[i];
    end
    unique case (rts_use)
      strap_pkg::rts_auto_flow: rts_nxt = !rx_room;
      strap_pkg::rts_half_duplex: rts_nxt = !(|core_tx_active);
      strap_pkg::rts_general: rts_nxt = !sw_rts;
    endcase
    irq_oe_nxt = core_irq;
    cts_nxt = chan_a_clear_to_send_n;
    gate_nxt = !auto_cts_en || !chan_a_clear_to_send_n;
    cs_nxt = !i2c_r && !addr_sel0_or_chip_select_n;
    addr_nxt = {strap_pkg::i2c_base_addr_hi,
      addr_sel1_or_serial_in, addr_sel0_or_chip_select_n};
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_r <= {2{!ir_nxt}};
      rx_r <= {2{!ir_nxt}};
      rts_r <= 1'b1;
      irq_oe_r <= 1'b0;
      gate_r <= 1'b0;
      cts_r <= 1'b1;
      cs_r <= 1'b0;
      addr_r <= 7'h00;
    end else begin
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rts_r <= rts_nxt;
      irq_oe_r <= irq_oe_nxt;
      gate_r <= gate_nxt;
      cts_r <= cts_nxt;
      cs_r <= cs_nxt;
      addr_r <= i2c_r ? addr_nxt : addr_r;
    end
  end

  // idle level follows the line coding, also in reset
  assign tx_pin = tx_r;
  assign rx_to_core = rx_r;
  assign chan_a_request_to_send_n = rts_r;
  assign irq_out = 1'b0;
  assign irq_oe = irq_oe_r;
  assign ir_mode = ir_r;
  assign half_duplex_mode = hd_r;
  assign i2c_mode = i2c_r;
  assign i2c_slave_addr = addr_r;
  assign spi_select = cs_r;
  assign tx_allowed = gate_r;
  assign cts_level = cts_r;

  ////////////////////////////////////////////////////////////////////
  // shared modem / gpio pins; term ready outputs, others inputs
  localparam logic [3:0] modem_outputs = 4'h0_003;
  for (genvar g = 0; g < strap_pkg::gpio_count; g++) begin : g_pin
    shared_pin_cell u_cell (
      .clk(clk),
      .nrst(nrst),
      .modem_sel(io_function_control[strap_pkg::modem_sel_bit]),
      .gpio_dir_out(io_direction_control[g]),
      .gpio_out_val(gpio_out_val[g]),
      .modem_is_output(modem_outputs[g]),
      .modem_out_val(modem_out_val[g]),
      .pin_in(shared_pin_in[g]),
      .pin_out(shared_pin_out[g]),
      .pin_oe(shared_pin_oe[g]),
      .pin_level(shared_level[g])
    );
  end
endmodule // pin_strap_config

// ---- core/strap_pkg.sv ----
// package: constants for the pin strap and function select block
// assumes a single 10 MHz clock and synchronous active-low reset
package strap_pkg;
  localparam int unsigned clk_period_ns = 100;
  localparam int unsigned reset_min_ns = 40;
  localparam int unsigned reset_min_cycles =
    (reset_min_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned modem_sel_bit = 1;
  localparam int unsigned gpio_count = 4;
  localparam logic [7:0] io_function_reset = 8'h00;
  localparam logic [7:0] io_direction_reset = 8'h00;
  localparam logic [4:0] i2c_base_addr_hi = 5'h0_01A;
  typedef enum logic [1:0] {
    rts_auto_flow,
    rts_half_duplex,
    rts_general
  } rts_use_e;
endpackage

// ---- core/shared_pin_cell.sv ----
// shared pin cell: gpio or modem signal on one two-way pin
// assumes pin inputs synchronous to clk
`timescale 1ns/1ps
module shared_pin_cell (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // selection
  input wire logic modem_sel,
  input wire logic gpio_dir_out,
  input wire logic gpio_out_val,
  input wire logic modem_is_output,
  input wire logic modem_out_val,
  // pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // sampled level
  output logic pin_level
);
  logic out_r, out_nxt, oe_r, oe_nxt, lvl_r, lvl_nxt;

  always_comb begin
    if (modem_sel) begin
      oe_nxt = modem_is_output;
      out_nxt = modem_out_val;
    end else begin
      oe_nxt = gpio_dir_out;
      out_nxt = gpio_out_val;
    end
    lvl_nxt = pin_in;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_r <= 1'b1;
      oe_r <= 1'b0;
      lvl_r <= 1'b1;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign pin_out = out_r;
  assign pin_oe = oe_r;
  assign pin_level = lvl_r;
endmodule // shared_pin_cell

// ---- tb/pin_strap_chk.sv ----
// checker: port assertions for pin_strap_config
// assumes one clock and synchronous active-low nrst
`timescale 1ns/1ps
module pin_strap_chk (
  // watched ports
  input wire logic clk, nrst, power_up, infrared_mode_strap_n,
  input wire logic half_duplex_dir_strap_n, host_i2c_sel, core_irq,
  input wire logic addr_sel0_or_chip_select_n, addr_sel1_or_serial_in,
  input wire logic [1:0] core_tx_active, tx_pin,
  input wire logic chan_a_request_to_send_n, irq_out, irq_oe, ir_mode,
  input wire logic half_duplex_mode, i2c_mode, spi_select,
  input wire logic [3:0] shared_pin_oe,
  input wire logic [6:0] i2c_slave_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RST_OUT:
    assert property (disable iff (1'b0) !nrst |=> chan_a_request_to_send_n
      && !irq_oe && shared_pin_oe == 4'h0) else $error("rst");
  AST_TX_IDLE:
    assert property (disable iff (1'b0) !nrst && !power_up |=>
      tx_pin == {2{!ir_mode}}) else $error("idle");
  AST_LOAD:
    assert property (power_up |=> ir_mode == !$past(infrared_mode_strap_n)
      && half_duplex_mode == !$past(half_duplex_dir_strap_n)
      && i2c_mode == $past(host_i2c_sel)) else $error("load");
  AST_HOLD:
    assert property (!power_up |=> $stable(ir_mode) && $stable(i2c_mode)
      && $stable(half_duplex_mode)) else $error("hold");
  AST_IRQ:
    assert property ($past(nrst) |-> irq_oe == $past(core_irq) && !irq_out)
      else $error("irq");
  AST_ADDR:
    assert property ($past(nrst) && i2c_mode && $stable(i2c_mode) |->
      i2c_slave_addr == {strap_pkg::i2c_base_addr_hi,
      $past(addr_sel1_or_serial_in), $past(addr_sel0_or_chip_select_n)})
      else $error("addr");
  AST_SPI:
    assert property ($past(nrst) |-> spi_select ==
      (!$past(i2c_mode) && !$past(addr_sel0_or_chip_select_n)))
      else $error("spi");
  AST_HD:
    assert property ($past(nrst) && $past(half_duplex_mode) |->
      chan_a_request_to_send_n == ~|$past(core_tx_active)) else $error("dir");
endmodule // pin_strap_chk
bind pin_strap_config pin_strap_chk chk_u (.*);

// ---- tb/host_model.sv ----
// host model: frames transfers with chip select
// assumes the bench clock; data toggles while deselected
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // host pins
  output logic cs_n,
  output logic sdi
);
  logic [3:0] cnt = 4'h0;
  initial {cs_n, sdi} = 2'h2;
  always @(posedge clk) begin
    #5 cnt <= cnt + 4'h1;
    cs_n <= cnt > 4'h9;
    sdi <= cs_n ? ~sdi : cnt[0];
  end
endmodule // host_model

// ---- tb/tb_top.sv ----
// bench: random and corner stimulus for pin_strap_config
// assumes host_model drives the host select pins
`timescale 1ns/1ps
module tb_top;
  logic clk, nrst, power_up, infrared_mode_strap_n, half_duplex_dir_strap_n;
  logic host_i2c_sel, addr_sel0_or_chip_select_n, addr_sel1_or_serial_in;
  logic core_irq, auto_rts_en, auto_cts_en, rx_room, sw_rts, irq_out, irq_oe;
  logic chan_a_clear_to_send_n, chan_a_request_to_send_n, ir_mode, i2c_mode;
  logic half_duplex_mode, spi_select, tx_allowed, cts_level, e_ir, e_hd, e_i2c;
  logic [1:0] core_tx_data, core_tx_active, rx_pin, tx_pin, rx_to_core;
  logic [7:0] io_function_control, io_direction_control, gpio_out_val;
  logic [3:0] modem_out_val, shared_pin_in, shared_pin_out, shared_pin_oe;
  logic [3:0] shared_level;
  logic [6:0] i2c_slave_addr;
  logic [31:0] r;
  logic [19:0] ex;
  integer seed = 32'h5f60;
  int fails = 0, num_checks = 0;
  pin_strap_config dut_u (.*);
  host_model host_u (.clk(clk), .cs_n(addr_sel0_or_chip_select_n),
    .sdi(addr_sel1_or_serial_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  function logic [6:0] ea();
    return {strap_pkg::i2c_base_addr_hi, addr_sel1_or_serial_in,
      addr_sel0_or_chip_select_n};
  endfunction
  // registered outputs expected from the inputs at the coming edge
  function logic [19:0] eo();
    logic ms;
    ms = io_function_control[strap_pkg::modem_sel_bit];
    return {core_tx_active & core_tx_data | ~core_tx_active & {2{!e_ir}},
      e_hd ? !(|core_tx_active) : (auto_rts_en ? !rx_room : !sw_rts),
      !auto_cts_en || !chan_a_clear_to_send_n, chan_a_clear_to_send_n,
      e_ir ? 2'h0 : rx_pin, ms ? 4'h3 : io_direction_control[3:0],
      ms ? modem_out_val : gpio_out_val[3:0], shared_pin_in, core_irq};
  endfunction
  task rnd;
    r = $random(seed);
    {core_tx_data, core_tx_active, core_irq, auto_rts_en, auto_cts_en, rx_room,
      sw_rts, chan_a_clear_to_send_n, rx_pin, shared_pin_in, modem_out_val,
      io_function_control} = r[27:0];
    r = $random(seed);
    {io_direction_control, gpio_out_val} = r[15:0];
    if (!power_up)
      {infrared_mode_strap_n, half_duplex_dir_strap_n, host_i2c_sel} = r[18:16];
  endtask
  task step;
    ex = eo();
    @(posedge clk);
    #1 chk("mode", {e_ir, e_hd, e_i2c}, {ir_mode, half_duplex_mode, i2c_mode});
    if (!nrst) chk("rst", {!e_ir, !e_ir}, tx_pin);
    else if (!power_up) begin
      chk("spi", !i2c_mode && !addr_sel0_or_chip_select_n, spi_select);
      if (i2c_mode) chk("addr", ea(), i2c_slave_addr);
      chk("tx", ex[19:18], tx_pin);
      chk("rts", ex[17], chan_a_request_to_send_n);
      chk("gate", ex[16], tx_allowed);
      chk("cts", ex[15], cts_level);
      chk("rx", ex[14:13], rx_to_core);
      chk("oe", ex[12:9], shared_pin_oe);
      chk("out", ex[8:5], shared_pin_out);
      chk("lvl", ex[4:1], shared_level);
      chk("irq", {ex[0], 1'b0}, {irq_oe, irq_out});
    end
    #4 rnd;
  endtask
  task stop_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    power_up = 1'b1;
    {infrared_mode_strap_n, half_duplex_dir_strap_n, host_i2c_sel} = 3'h0;
    {e_ir, e_hd, e_i2c} = 3'h6;
    rnd;
    repeat (20) step;
    nrst = 1'b1;
    for (int k = 0; k < 8; k++) begin
      power_up = 1'b1;
      {infrared_mode_strap_n, half_duplex_dir_strap_n, host_i2c_sel} = 3'(k);
      {e_ir, e_hd, e_i2c} = {!k[2], !k[1], k[0]};
      step;
      power_up = 1'b0;
      repeat (60) step;
      nrst = 1'b0;
      repeat (2) step;
      nrst = 1'b1;
    end
    stop_test;
  end
endmodule // tb_top
